// File: rtl/lie_params.svh
/*
 Register offsets, field positions and reset values of the low event register block.
 Assumes inclusion by bare name from the package only; the design modules use its macros without including it.
*/
`ifndef LIE_PARAMS_SVH
`define LIE_PARAMS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define LIE_OFS_EVENT_SET 8'h80
`define LIE_OFS_EVENT_CLR 8'h84
`define LIE_OFS_MASK_SET 8'h88
`define LIE_OFS_MASK_CLR 8'h8c
`define LIE_OFS_ITX_EV_SET 8'h90
`define LIE_OFS_ITX_EV_CLR 8'h94
`define LIE_OFS_ITX_MSK_SET 8'h98
`define LIE_OFS_ITX_MSK_CLR 8'h9c
`define LIE_OFS_IRX_EV_SET 8'ha0
`define LIE_OFS_IRX_EV_CLR 8'ha4
`define LIE_OFS_IRX_MSK_SET 8'ha8
`define LIE_OFS_IRX_MSK_CLR 8'hac

// ---------------------------------------------------------------
// Event bit positions
// ---------------------------------------------------------------
`define LIE_BIT_PHY_REQ 19
`define LIE_BIT_ACCESS_FAIL 18
`define LIE_BIT_BUS_RESET 17
`define LIE_BIT_SELF_ID 16
`define LIE_BIT_SELF_ID2 15
`define LIE_BIT_LOCK_ERR 9
`define LIE_BIT_POSTED_ERR 8
`define LIE_BIT_ISO_RX 7
`define LIE_BIT_ISO_TX 6
`define LIE_BIT_RESP_PKT 5
`define LIE_BIT_REQ_PKT 4
`define LIE_BIT_RX_RESP_DMA 3
`define LIE_BIT_RX_REQ_DMA 2
`define LIE_BIT_TX_RESP_DMA 1
`define LIE_BIT_TX_REQ_DMA 0
// Highest bit of the low half of the event register.
`define LIE_LOW_TOP 19
`define LIE_BIT_MASTER_EN 31

// Latched (sticky) event bits of the low half: 19..15, 9, 8, 5..0.
`define LIE_STICKY_MASK 32'h000f_833f
// Bits of the low half that exist in the mask register, plus bit 31.
`define LIE_MASK_MASK 32'h800f_83ff
`define LIE_RESET_VALUE 32'h0000_0000
`define LIE_UNMAPPED_READ 32'h0000_0000

`endif

// File: rtl/lie_pkg.sv
/*
 Types shared by the low event register block.
 Assumes the constants header is on the include path.
*/
package lie_pkg;
	`include "lie_params.svh"

	// Kind of bus access decoded for one register pair.
	typedef enum logic [1:0] {
		LIE_ACC_NONE,
		LIE_ACC_SET,
		LIE_ACC_CLR
	} lie_access_t;
endpackage

// File: rtl/lie_setclr_reg.sv
/*
 One set/clear register of configurable width with a hardware set input.
 Assumes a single clock domain with synchronous active-high reset.
*/
`timescale 1ns/10ps
module lie_setclr_reg
	import lie_pkg::*;
#(
	parameter int WIDTH = 32,
	parameter logic [31:0] KEEP = 32'hffff_ffff
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire lie_access_t access,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic [WIDTH-1:0] hw_set,
	input wire logic [WIDTH-1:0] hw_clr,
	output logic [WIDTH-1:0] value
);
	// ---------------------------------------------------------------
	// Storage
	// ---------------------------------------------------------------

	// Per bit: hardware set beats every clear, then hardware clear, then software set and clear.
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			if (KEEP[i]) begin : g_kept
				always_ff @(posedge clk) begin
					if (sys_rst) begin
						value[i] <= 1'b0;
					end else if (clk_en) begin
						if (hw_set[i]) begin
							value[i] <= 1'b1;
						end else if (hw_clr[i]) begin
							value[i] <= 1'b0;
						end else if (access == LIE_ACC_SET && wdata[i]) begin
							value[i] <= 1'b1;
						end else if (access == LIE_ACC_CLR && wdata[i]) begin
							value[i] <= 1'b0;
						end
					end
				end
			end else begin : g_zero
				// Unimplemented bits are held at zero by a flop of their own, so
				// every bit of the vector has exactly one procedural driver.
				always_ff @(posedge clk) begin
					value[i] <= 1'b0;
				end
			end
		end
	endgenerate
endmodule

// File: rtl/lie_event_low.sv
/*
 Lower half (bits 19..0) of the link interrupt event register with its mask,
 the isochronous transmit and receive event and mask registers, and the
 external interrupt output.
 Assumes event inputs are one-cycle pulses from logic on clk, except the
 PHY request, which comes from the PHY clock domain and is synchronised here.
*/
//
// How it works
// [RL1] PHY status-transfer interrupt request sets bit 19.
// [RL2] Failed PHY register access for missing link clock sets bit 18 immediately.
// [RL3] PHY entering bus reset sets bit 17.
// [RL4] End of self-identification stream reception sets bit 16.
// [RL5] Bit 16 clears in the same cycle that bit 17 sets.
// [RL6] Bit 15 sets with bit 16 and ignores bus reset.
// [RL7] Bits 14 to 10 always read as zero.
// [RL8] Lock response not answered with complete acknowledge sets bit 9.
// [RL9] Host bus error on posted write to memory sets bit 8.
// [RL10] Bit 7 is the unlatched OR of enabled isochronous receive events.
// [RL11] Bit 6 is the unlatched OR of enabled isochronous transmit events.
// [RL12] Response packet stored with status written back sets bit 5.
// [RL13] Request packet stored with status written back sets bit 4.
// [RL14] Receive response context descriptor completion may set bit 3.
// [RL15] Receive request context descriptor completion may set bit 2.
// [RL16] Response transmit context command completion may set bit 1.
// [RL17] Request transmit context command completion may set bit 0.
// [RL18] Writes to set/clear addresses set/clear bits; both addresses read contents.
// [RL19] Interrupt asserts only with master enable and some unmasked set event.
// [RL20] Latched event bits stay set until software clears them, except bit 16, which bus reset clears.
// [RL21] DMA completion bits set only when the descriptor requests an interrupt.
`timescale 1ns/10ps
module lie_event_low
	import lie_pkg::*;
#(
	parameter int ISO_TX_CONTEXTS = 32,
	parameter int ISO_RX_CONTEXTS = 32
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	input wire logic phy_status_request,
	input wire logic phy_access_failed,
	input wire logic bus_reset_seen,
	input wire logic self_ident_done,
	input wire logic lock_response_error,
	input wire logic posted_write_error,
	input wire logic response_packet_stored,
	input wire logic request_packet_stored,
	input wire logic async_rx_response_dma,
	input wire logic async_rx_request_dma,
	input wire logic async_tx_response_dma,
	input wire logic async_tx_request_dma,
	input wire logic [3:0] dma_irq_requested,
	input wire logic [ISO_TX_CONTEXTS-1:0] iso_tx_done,
	input wire logic [ISO_RX_CONTEXTS-1:0] iso_rx_done,
	output logic interrupt_out,
	output logic [19:0] events_low
);
	// ---------------------------------------------------------------
	// Input synchroniser for the PHY request
	// ---------------------------------------------------------------
	logic phy_req_meta;
	logic phy_req_sync;
	logic phy_req_prev;

	// Two flops bring the PHY-domain request level into clk.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			phy_req_meta <= 1'b0;
			phy_req_sync <= 1'b0;
		end else if (clk_en) begin
			phy_req_meta <= phy_status_request;
			phy_req_sync <= phy_req_meta;
		end
	end

	// Keeps the previous synchronised level for rising-edge detection.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			phy_req_prev <= 1'b0;
		end else if (clk_en) begin
			phy_req_prev <= phy_req_sync;
		end
	end

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	lie_access_t acc_event;
	lie_access_t acc_mask;
	lie_access_t acc_itx_ev;
	lie_access_t acc_itx_msk;
	lie_access_t acc_irx_ev;
	lie_access_t acc_irx_msk;

	// Turns a write strobe at a set or clear address into an access kind.
	function automatic lie_access_t decode(input logic [7:0] set_ofs,
			input logic [7:0] clr_ofs, input logic wr, input logic [7:0] addr);
		lie_access_t kind;
		kind = LIE_ACC_NONE;
		if (wr && addr == set_ofs) begin
			kind = LIE_ACC_SET;
		end else if (wr && addr == clr_ofs) begin
			kind = LIE_ACC_CLR;
		end
		return kind;
	endfunction

	// One decoded access per register pair.
	always_comb begin
		acc_event = decode(`LIE_OFS_EVENT_SET, `LIE_OFS_EVENT_CLR, reg_write, reg_addr); // RL18
		acc_mask = decode(`LIE_OFS_MASK_SET, `LIE_OFS_MASK_CLR, reg_write, reg_addr);
		acc_itx_ev = decode(`LIE_OFS_ITX_EV_SET, `LIE_OFS_ITX_EV_CLR, reg_write, reg_addr);
		acc_itx_msk = decode(`LIE_OFS_ITX_MSK_SET, `LIE_OFS_ITX_MSK_CLR, reg_write, reg_addr);
		acc_irx_ev = decode(`LIE_OFS_IRX_EV_SET, `LIE_OFS_IRX_EV_CLR, reg_write, reg_addr);
		acc_irx_msk = decode(`LIE_OFS_IRX_MSK_SET, `LIE_OFS_IRX_MSK_CLR, reg_write, reg_addr);
	end

	// ---------------------------------------------------------------
	// Hardware event sources
	// ---------------------------------------------------------------
	logic [31:0] ev_set;
	logic [31:0] ev_clr;
	logic [31:0] event_q;
	logic [31:0] mask_q;

	// Maps each source onto its event bit; self-ID clear rides on bus reset.
	always_comb begin
		ev_set = 32'h0000_0000;
		ev_clr = 32'h0000_0000;
		ev_set[`LIE_BIT_PHY_REQ] = phy_req_sync & ~phy_req_prev; // RL1
		ev_set[`LIE_BIT_ACCESS_FAIL] = phy_access_failed; // RL2
		ev_set[`LIE_BIT_BUS_RESET] = bus_reset_seen; // RL3
		ev_set[`LIE_BIT_SELF_ID] = self_ident_done; // RL4
		ev_set[`LIE_BIT_SELF_ID2] = self_ident_done; // RL6
		ev_set[`LIE_BIT_LOCK_ERR] = lock_response_error; // RL8
		ev_set[`LIE_BIT_POSTED_ERR] = posted_write_error; // RL9
		ev_set[`LIE_BIT_RESP_PKT] = response_packet_stored; // RL12
		ev_set[`LIE_BIT_REQ_PKT] = request_packet_stored; // RL13
		// A DMA completion only counts when its descriptor asked for an interrupt.
		// The qualifier bit shares its index with the event bit it gates.
		ev_set[`LIE_BIT_RX_RESP_DMA] = async_rx_response_dma &
			dma_irq_requested[`LIE_BIT_RX_RESP_DMA]; // RL14 RL21
		ev_set[`LIE_BIT_RX_REQ_DMA] = async_rx_request_dma &
			dma_irq_requested[`LIE_BIT_RX_REQ_DMA]; // RL15 RL21
		ev_set[`LIE_BIT_TX_RESP_DMA] = async_tx_response_dma &
			dma_irq_requested[`LIE_BIT_TX_RESP_DMA]; // RL16 RL21
		ev_set[`LIE_BIT_TX_REQ_DMA] = async_tx_request_dma &
			dma_irq_requested[`LIE_BIT_TX_REQ_DMA]; // RL17 RL21
		// A self-ID done in the same cycle as a bus reset loses bit 16 to the reset; bit 15 still sets.
		if (bus_reset_seen) begin
			ev_set[`LIE_BIT_SELF_ID] = 1'b0;
			ev_clr[`LIE_BIT_SELF_ID] = 1'b1; // RL5
		end
	end

	// ---------------------------------------------------------------
	// Event, mask and isochronous registers
	// ---------------------------------------------------------------
	logic [ISO_TX_CONTEXTS-1:0] itx_ev_q;
	logic [ISO_TX_CONTEXTS-1:0] itx_msk_q;
	logic [ISO_RX_CONTEXTS-1:0] irx_ev_q;
	logic [ISO_RX_CONTEXTS-1:0] irx_msk_q;

	// Sticky event bits; reserved and summary bits stay zero here.
	lie_setclr_reg #(.WIDTH(32), .KEEP(`LIE_STICKY_MASK)) u_event (
		.clk(clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.access(acc_event),
		.wdata(reg_wdata),
		.hw_set(ev_set),
		.hw_clr(ev_clr),
		.value(event_q)
	); // RL20 RL7

	// Mask register for the low half plus the master enable.
	lie_setclr_reg #(.WIDTH(32), .KEEP(`LIE_MASK_MASK)) u_mask (
		.clk(clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.access(acc_mask),
		.wdata(reg_wdata),
		.hw_set(32'h0000_0000),
		.hw_clr(32'h0000_0000),
		.value(mask_q)
	);

	// Isochronous transmit context events.
	lie_setclr_reg #(.WIDTH(ISO_TX_CONTEXTS)) u_itx_ev (
		.clk(clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.access(acc_itx_ev),
		.wdata(reg_wdata[ISO_TX_CONTEXTS-1:0]),
		.hw_set(iso_tx_done),
		.hw_clr({ISO_TX_CONTEXTS{1'b0}}),
		.value(itx_ev_q)
	);

	// Isochronous transmit context mask.
	lie_setclr_reg #(.WIDTH(ISO_TX_CONTEXTS)) u_itx_msk (
		.clk(clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.access(acc_itx_msk),
		.wdata(reg_wdata[ISO_TX_CONTEXTS-1:0]),
		.hw_set({ISO_TX_CONTEXTS{1'b0}}),
		.hw_clr({ISO_TX_CONTEXTS{1'b0}}),
		.value(itx_msk_q)
	);

	// Isochronous receive context events.
	lie_setclr_reg #(.WIDTH(ISO_RX_CONTEXTS)) u_irx_ev (
		.clk(clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.access(acc_irx_ev),
		.wdata(reg_wdata[ISO_RX_CONTEXTS-1:0]),
		.hw_set(iso_rx_done),
		.hw_clr({ISO_RX_CONTEXTS{1'b0}}),
		.value(irx_ev_q)
	);

	// Isochronous receive context mask.
	lie_setclr_reg #(.WIDTH(ISO_RX_CONTEXTS)) u_irx_msk (
		.clk(clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.access(acc_irx_msk),
		.wdata(reg_wdata[ISO_RX_CONTEXTS-1:0]),
		.hw_set({ISO_RX_CONTEXTS{1'b0}}),
		.hw_clr({ISO_RX_CONTEXTS{1'b0}}),
		.value(irx_msk_q)
	);

	// ---------------------------------------------------------------
	// Event view with unlatched summaries
	// ---------------------------------------------------------------
	logic [31:0] event_view;

	// Summary bits follow the isochronous registers without latching.
	always_comb begin
		event_view = event_q;
		event_view[`LIE_BIT_ISO_RX] = |(irx_ev_q & irx_msk_q); // RL10
		event_view[`LIE_BIT_ISO_TX] = |(itx_ev_q & itx_msk_q); // RL11
	end

	// ---------------------------------------------------------------
	// Read port
	// ---------------------------------------------------------------
	logic [31:0] next_rdata;

	// Both addresses of a pair read the same contents; others read zero.
	always_comb begin
		case (reg_addr)
			`LIE_OFS_EVENT_SET, `LIE_OFS_EVENT_CLR: next_rdata = event_view; // RL18 RL7
			`LIE_OFS_MASK_SET, `LIE_OFS_MASK_CLR: next_rdata = mask_q;
			`LIE_OFS_ITX_EV_SET, `LIE_OFS_ITX_EV_CLR: next_rdata = 32'(itx_ev_q);
			`LIE_OFS_ITX_MSK_SET, `LIE_OFS_ITX_MSK_CLR: next_rdata = 32'(itx_msk_q);
			`LIE_OFS_IRX_EV_SET, `LIE_OFS_IRX_EV_CLR: next_rdata = 32'(irx_ev_q);
			`LIE_OFS_IRX_MSK_SET, `LIE_OFS_IRX_MSK_CLR: next_rdata = 32'(irx_msk_q);
			default: next_rdata = `LIE_UNMAPPED_READ;
		endcase
	end

	// Read data stands only in the cycle after the read strobe.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= `LIE_RESET_VALUE;
		end else if (clk_en) begin
			reg_rdata <= reg_read ? next_rdata : `LIE_RESET_VALUE;
		end
	end

	// ---------------------------------------------------------------
	// Interrupt output and event export
	// ---------------------------------------------------------------
	logic [`LIE_LOW_TOP:0] pending;
	logic master_enable;

	// Events that are both set and enabled; the upper half is combined elsewhere.
	// The master enable is kept apart so software can mute the pin without
	// losing the individual enables.
	always_comb begin
		pending = event_view[`LIE_LOW_TOP:0] & mask_q[`LIE_LOW_TOP:0];
		master_enable = mask_q[`LIE_BIT_MASTER_EN];
	end

	// Registered so the interrupt pin is glitch free.
	// The pin therefore trails the event bit by one cycle.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			interrupt_out <= 1'b0;
		end else if (clk_en) begin
			interrupt_out <= master_enable & (|pending); // RL19
		end
	end

	// Registered copy of the low event bits for the upper-half logic.
	// It moves in step with the interrupt pin, so both show the same view.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			events_low <= 20'h0_0000;
		end else if (clk_en) begin
			events_low <= event_view[`LIE_LOW_TOP:0];
		end
	end
endmodule

// File: test/lie_event_source.sv
/*
 Stand-in for the PHY and the DMA units that feed the low event register.
 Assumes the bench asks for each event one clock before it must appear.
*/
`timescale 1ns/10ps
module lie_event_source (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [10:0] fire,
	input wire logic phy_level,
	output logic [10:0] pulse,
	output logic phy_status_request
);
	// Each requested event leaves as a single clock pulse one cycle later.
	always_ff @(posedge clk) begin
		pulse <= sys_rst ? 11'h000 : fire;
	end
	// The PHY request is a level that holds until the PHY withdraws it.
	always_ff @(posedge clk) begin
		phy_status_request <= phy_level;
	end
endmodule

// File: test/lie_event_low_asserts.sv
/*
 Checker of the low event register block.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/10ps
module lie_event_low_asserts (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [7:0] reg_addr,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [31:0] reg_rdata,
	input wire logic phy_status_request,
	input wire logic phy_access_failed,
	input wire logic bus_reset_seen,
	input wire logic self_ident_done,
	input wire logic lock_response_error,
	input wire logic async_rx_response_dma,
	input wire logic [3:0] dma_irq_requested,
	input wire logic interrupt_out,
	input wire logic [19:0] events_low
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic clr_wr;
	// A write to the clear address may lower any latched bit.
	assign clr_wr = reg_write && reg_addr == 8'h84;
	property p_phy; clk_en && $rose(phy_status_request) |-> ##[1:5] events_low[19]; endproperty
	a_phy: assert property (p_phy) else $error("phy request not latched");
	property p_fail; phy_access_failed |-> ##[1:2] events_low[18]; endproperty
	a_fail: assert property (p_fail) else $error("access failure not latched");
	property p_bus; bus_reset_seen |-> ##[1:2] (events_low[17] && !events_low[16]); endproperty
	a_bus: assert property (p_bus) else $error("bus reset bits wrong");
	property p_sid; self_ident_done && !bus_reset_seen |-> ##[1:2] (&events_low[16:15]); endproperty
	a_sid: assert property (p_sid) else $error("self id bits not set");
	property p_lock; lock_response_error |-> ##[1:2] events_low[9]; endproperty
	a_lock: assert property (p_lock) else $error("lock error not latched");
	property p_qual; async_rx_response_dma && !dma_irq_requested[3] && !events_low[3]
		&& !reg_write |=> !events_low[3] [*2]; endproperty
	a_qual: assert property (p_qual) else $error("unrequested dma bit set");
	property p_keep; events_low[18] && !clr_wr && !$past(clr_wr) |=> events_low[18]; endproperty
	a_keep: assert property (p_keep) else $error("latched bit lost");
	property p_irq; events_low == 20'h0 [*3] |-> !interrupt_out; endproperty
	a_irq: assert property (p_irq) else $error("interrupt without event");
	property p_idle; clk_en && !reg_read |=> reg_rdata == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("read data outside read");
	property p_rsvd; reg_read && reg_addr == 8'h80 |=> reg_rdata[14:10] == 5'h0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
	c_bus: cover property (bus_reset_seen ##[1:2] events_low[15]);
	c_irq: cover property ($rose(interrupt_out));
	c_qual: cover property (async_rx_response_dma && !dma_irq_requested[3]);
endmodule
bind lie_event_low lie_event_low_asserts u_asserts (.clk(clk), .sys_rst(sys_rst),
	.clk_en(clk_en), .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
	.reg_rdata(reg_rdata), .phy_status_request(phy_status_request),
	.phy_access_failed(phy_access_failed), .bus_reset_seen(bus_reset_seen),
	.self_ident_done(self_ident_done), .lock_response_error(lock_response_error),
	.async_rx_response_dma(async_rx_response_dma), .dma_irq_requested(dma_irq_requested),
	.interrupt_out(interrupt_out), .events_low(events_low));

// File: test/test_link_interrupt_event_low.sv
/*
 Self-checking bench of the low event register block.
 Assumes the event source model and the checker are compiled beside it.
*/
`timescale 1ns/10ps
module test_link_interrupt_event_low;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [10:0] fire = 11'h0;
	logic phy_level = 1'b0;
	logic [3:0] dma_irq_requested = 4'h0;
	logic [3:0] iso_tx_done = 4'h0;
	logic [3:0] iso_rx_done = 4'h0;
	logic rd_q = 1'b0;
	logic [31:0] reg_rdata;
	logic [10:0] p;
	logic phy_status_request;
	logic interrupt_out;
	logic [19:0] events_low;
	logic [31:0] exp_q[$];
	logic [31:0] model, d, m, iso;
	int n_errors = 0;
	int cmp_count = 0;
	int seed = 54138;
	int pos [11] = '{0, 1, 2, 3, 4, 5, 8, 9, 16, 17, 18};
	// Clock of 50 ns.
	always #25 clk = ~clk;
	lie_event_source u_src (.clk(clk), .sys_rst(sys_rst), .fire(fire), .phy_level(phy_level),
		.pulse(p), .phy_status_request(phy_status_request));
	lie_event_low #(.ISO_TX_CONTEXTS(4), .ISO_RX_CONTEXTS(4)) u_dut (.clk(clk),
		.sys_rst(sys_rst), .clk_en(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.phy_status_request(phy_status_request), .phy_access_failed(p[10]),
		.bus_reset_seen(p[9]), .self_ident_done(p[8]), .lock_response_error(p[7]),
		.posted_write_error(p[6]), .response_packet_stored(p[5]),
		.request_packet_stored(p[4]), .async_rx_response_dma(p[3]),
		.async_rx_request_dma(p[2]), .async_tx_response_dma(p[1]),
		.async_tx_request_dma(p[0]), .dma_irq_requested(dma_irq_requested),
		.iso_tx_done(iso_tx_done), .iso_rx_done(iso_rx_done),
		.interrupt_out(interrupt_out), .events_low(events_low));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One bus cycle; a read leaves its expected answer for the monitor.
	task automatic cyc(input logic w, r, input logic [7:0] a, input logic [31:0] v,
		input logic [10:0] f);
		reg_write <= w;
		reg_read <= r;
		reg_addr <= a;
		reg_wdata <= v;
		fire <= f;
		if (r) exp_q.push_back(v);
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		cyc(1'b0, 1'b1, a, e, 11'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		cyc(1'b1, 1'b0, a, v, 11'h0);
	endtask
	task automatic idle();
		cyc(1'b0, 1'b0, 8'h00, 32'h0, 11'h0);
	endtask
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Monitor: read data stand only in the cycle after the read strobe.
	always @(posedge clk) begin
		if (rd_q) begin
			chk(reg_rdata, exp_q.pop_front());
		end
		rd_q <= reg_read;
	end
	// Watchdog that cuts a hang short.
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		report_and_stop();
	end
	// Main sequence.
	initial begin
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		model = 32'h0;
		iso = 32'h0;
		rd(8'h80, 32'h0);
		rd(8'h88, 32'h0);
		rd(8'h40, 32'h0);
		$display("done: reset");
		dma_irq_requested <= 4'hf;
		for (int i = 0; i < 11; i++) begin
			cyc(1'b0, 1'b0, 8'h00, 32'h0, 11'h1 << i);
			idle();
			model = model | (32'h1 << pos[i]);
			if (pos[i] == 16) model = model | 32'h8000;
			if (pos[i] == 17) model = model & ~32'h1_0000;
			rd(8'h80, model);
			rd(8'h84, model);
			chk({12'h0, events_low}, model);
		end
		cyc(1'b0, 1'b0, 8'h00, 32'h0, 11'h4ff);
		idle();
		rd(8'h80, model);
		d = $random(seed);
		wr(8'h84, d);
		model = model & ~d;
		rd(8'h80, model);
		wr(8'h84, 32'hffff_ffff);
		$display("done: events");
		for (int i = 0; i < 4; i++) begin
			m = $random(seed);
			dma_irq_requested <= m[3:0];
			cyc(1'b0, 1'b0, 8'h00, 32'h0, 11'h00f);
			idle();
			rd(8'h80, {28'h0, m[3:0]});
			wr(8'h84, 32'hf);
		end
		wr(8'h80, 32'hffff_ffff);
		rd(8'h84, 32'h000f_833f);
		wr(8'h88, 32'h8002_0000);
		idle();
		idle();
		chk({31'h0, interrupt_out}, 32'h1);
		wr(8'h8c, 32'h8000_0000);
		idle();
		idle();
		chk({31'h0, interrupt_out}, 32'h0);
		wr(8'h84, 32'hffff_ffff);
		$display("done: set and mask");
		for (int i = 0; i < 4; i++) begin
			d = $random(seed);
			m = $random(seed);
			iso = iso | d;
			iso_tx_done <= d[3:0];
			iso_rx_done <= d[7:4];
			wr(8'h98, {28'h0, m[3:0]});
			iso_tx_done <= 4'h0;
			iso_rx_done <= 4'h0;
			wr(8'ha8, {28'h0, m[7:4]});
			idle();
			idle();
			rd(8'h80, {24'h0, |(iso[7:4] & m[7:4]), |(iso[3:0] & m[3:0]), 6'h0});
			wr(8'h9c, 32'hf);
			wr(8'hac, 32'hf);
			idle();
			idle();
			rd(8'h80, 32'h0);
		end
		$display("done: iso");
		phy_level <= 1'b1;
		repeat (4) idle();
		rd(8'h80, 32'h0008_0000);
		phy_level <= 1'b0;
		wr(8'h84, 32'h0008_0000);
		idle();
		idle();
		chk(32'(exp_q.size()), 32'h0);
		$display("done: phy");
		report_and_stop();
	end
endmodule
